// [core/i2crb_slave.sv]
// Contract
// - device address is 01000 followed by high strap then low strap.
// - bank holds 128 byte-wide locations reached over the serial interface.
// - locations 0..80 are read/write, 96..127 are read-only.
// - data line is sampled on each rising edge of the clock line.
// - matching address is acknowledged by pulling data low for the ninth clock.
// - every written byte is acknowledged on its ninth rising clock edge.
// - each further write byte goes to the next consecutive location.
// - data rising while clock is high is a stop and ends the transfer.
// - read begins with address plus write bit and pointer, both acknowledged.
// - repeated start with read bit is acknowledged, then selected register is driven.
// - read ends on a master not-acknowledge and stop; data line is released.
`timescale 1ns/10ps
`default_nettype none
module i2crb_slave (
	// system clock domain
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// oversampling clock for the serial pins
	input wire logic i_link_clk,
	// serial bus pins, open drain data
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// address straps
	input wire logic i_addr_strap_low,
	input wire logic i_addr_strap_high,
	// read-only status bytes, index 0 sits at location 96
	input wire logic [31:0][7:0] i_ro_bank,
	// configuration write notification and contents
	output logic o_cfg_wr,
	output logic [6:0] o_cfg_addr,
	output logic [7:0] o_cfg_data,
	output logic [80:0][7:0] o_cfg_bank
);

	typedef struct packed {
		logic scl_m;
		logic scl_s;
		logic scl_q;
		logic sda_m;
		logic sda_s;
		logic sda_q;
		logic ce_m;
		logic ce_s;
		logic [1:0] strap_m;
		logic [1:0] strap_s;
		logic ack_m;
		logic ack_s;
		logic ack_q;
		i2crb_pkg::i2crb_state_t st;
		i2crb_pkg::i2crb_state_t ack_next;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [7:0] tx;
		logic [6:0] ptr;
		logic sda_oe;
		logic req_tgl;
		i2crb_pkg::i2crb_req_t req;
		logic [7:0] rd_hold;
	} i2crb_link_t;

	typedef struct packed {
		logic req_m;
		logic req_s;
		logic req_q;
		logic ack_tgl;
		logic [7:0] rd_data;
		logic [80:0][7:0] bank;
		logic cfg_wr;
		logic [6:0] cfg_addr;
		logic [7:0] cfg_data;
	} i2crb_sys_t;

	// locations the master may change and that appear on o_cfg_bank
	function automatic logic bank_is_rw(input logic [6:0] addr);
		bank_is_rw = (addr <= i2crb_pkg::RW_LAST);
	endfunction

	// status window at the top of the map, fed from i_ro_bank
	function automatic logic bank_is_ro(input logic [6:0] addr);
		bank_is_ro = (addr >= i2crb_pkg::RO_FIRST);
	endfunction

	// read path: configuration, status, or a fixed filler for the gap 81..95
	function automatic logic [7:0] bank_read(
		input logic [6:0] addr,
		input logic [80:0][7:0] cfg,
		input logic [31:0][7:0] ro
	);
		if (bank_is_rw(addr)) begin
			bank_read = cfg[addr];
		end else if (bank_is_ro(addr)) begin
			// 96..127 map onto status index 0..31 by the low five bits
			bank_read = ro[addr[4:0]];
		end else begin
			bank_read = i2crb_pkg::UNMAPPED_VALUE;
		end
	endfunction

	i2crb_link_t link_r;
	i2crb_link_t link_nxt;
	i2crb_sys_t sys_r;
	i2crb_sys_t sys_nxt;

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [6:0] own_addr;
	logic addr_match;

	// bus events, all taken from the second synchroniser stage onward
	always_comb begin
		scl_rise = link_r.scl_s & ~link_r.scl_q;
		scl_fall = ~link_r.scl_s & link_r.scl_q;
		bus_start = link_r.scl_s & link_r.scl_q & link_r.sda_q & ~link_r.sda_s;
		bus_stop = link_r.scl_s & link_r.scl_q & ~link_r.sda_q & link_r.sda_s;
		own_addr = {i2crb_pkg::DEV_ADDR_BASE, link_r.strap_s[1], link_r.strap_s[0]};
		addr_match = (link_r.shift[7:1] == own_addr);
	end

	// link domain: serial protocol engine
	always_comb begin
		link_nxt = link_r;
		// synchronisers run even while frozen so no stale level is released later
		link_nxt.scl_m = i_scl;
		link_nxt.scl_s = link_r.scl_m;
		link_nxt.sda_m = i_sda;
		link_nxt.sda_s = link_r.sda_m;
		link_nxt.ce_m = i_ce;
		link_nxt.ce_s = link_r.ce_m;
		link_nxt.strap_m = {i_addr_strap_high, i_addr_strap_low};
		link_nxt.strap_s = link_r.strap_m;
		link_nxt.ack_m = sys_r.ack_tgl;
		link_nxt.ack_s = link_r.ack_m;
		if (link_r.ce_s) begin
			link_nxt.scl_q = link_r.scl_s;
			link_nxt.sda_q = link_r.sda_s;
			link_nxt.ack_q = link_r.ack_s;
			// read data is stable in the system domain once its toggle is seen here
			if (link_r.ack_s != link_r.ack_q) begin
				link_nxt.rd_hold = sys_r.rd_data;
			end
			if (bus_start) begin
				// a repeated start keeps the pointer
				link_nxt.st = i2crb_pkg::ST_ADDR;
				link_nxt.cnt = i2crb_pkg::BIT_ZERO;
				link_nxt.sda_oe = 1'b0;
			end else if (bus_stop) begin
				link_nxt.st = i2crb_pkg::ST_IDLE;
				link_nxt.sda_oe = 1'b0;
			end else begin
				case (link_r.st)
					i2crb_pkg::ST_ADDR,
					i2crb_pkg::ST_REG,
					i2crb_pkg::ST_WDATA: begin
						if (scl_rise && link_r.cnt < i2crb_pkg::BITS_PER_BYTE) begin
							link_nxt.shift = {link_r.shift[6:0], link_r.sda_s};
							link_nxt.cnt = link_r.cnt + i2crb_pkg::BIT_ONE;
						end else if (scl_fall && link_r.cnt == i2crb_pkg::BITS_PER_BYTE) begin
							link_nxt.cnt = i2crb_pkg::BIT_ZERO;
							link_nxt.st = i2crb_pkg::ST_ACK;
							link_nxt.sda_oe = 1'b1;
							if (link_r.st == i2crb_pkg::ST_ADDR) begin
								if (!addr_match) begin
									// stay off the bus until the next start
									link_nxt.st = i2crb_pkg::ST_IDLE;
									link_nxt.sda_oe = 1'b0;
								end else if (link_r.shift[0]) begin
									// fetch early: a full clock period passes before bit 7
									link_nxt.ack_next = i2crb_pkg::ST_RDATA;
									link_nxt.req.wr = 1'b0;
									link_nxt.req.addr = link_r.ptr;
									link_nxt.req_tgl = ~link_r.req_tgl;
								end else begin
									link_nxt.ack_next = i2crb_pkg::ST_REG;
								end
							end else if (link_r.st == i2crb_pkg::ST_REG) begin
								// top bit of the pointer byte has no location behind it
								link_nxt.ptr = link_r.shift[6:0];
								link_nxt.ack_next = i2crb_pkg::ST_WDATA;
							end else begin
								link_nxt.req.wr = 1'b1;
								link_nxt.req.addr = link_r.ptr;
								link_nxt.req.data = link_r.shift;
								link_nxt.req_tgl = ~link_r.req_tgl;
								link_nxt.ptr = i2crb_pkg::i2crb_ptr_inc(link_r.ptr);
								link_nxt.ack_next = i2crb_pkg::ST_WDATA;
							end
						end
					end
					i2crb_pkg::ST_ACK: begin
						if (scl_fall) begin
							link_nxt.st = link_r.ack_next;
							link_nxt.cnt = i2crb_pkg::BIT_ZERO;
							link_nxt.sda_oe = 1'b0;
							if (link_r.ack_next == i2crb_pkg::ST_RDATA) begin
								// a one is sent by letting go of the line
								link_nxt.sda_oe = ~link_r.rd_hold[7];
								link_nxt.tx = {link_r.rd_hold[6:0], 1'b0};
								link_nxt.cnt = i2crb_pkg::BIT_ONE;
							end
						end
					end
					i2crb_pkg::ST_RDATA: begin
						if (scl_fall) begin
							if (link_r.cnt < i2crb_pkg::BITS_PER_BYTE) begin
								link_nxt.sda_oe = ~link_r.tx[7];
								link_nxt.tx = {link_r.tx[6:0], 1'b0};
								link_nxt.cnt = link_r.cnt + i2crb_pkg::BIT_ONE;
							end else begin
								link_nxt.sda_oe = 1'b0;
								link_nxt.st = i2crb_pkg::ST_RACK;
							end
						end
					end
					i2crb_pkg::ST_RACK: begin
						if (scl_rise) begin
							if (link_r.sda_s) begin
								link_nxt.st = i2crb_pkg::ST_IDLE;
							end else begin
								link_nxt.ptr = i2crb_pkg::i2crb_ptr_inc(link_r.ptr);
								link_nxt.req.wr = 1'b0;
								link_nxt.req.addr = i2crb_pkg::i2crb_ptr_inc(link_r.ptr);
								link_nxt.req_tgl = ~link_r.req_tgl;
								// line stays released; ack state only waits for the fall
								link_nxt.st = i2crb_pkg::ST_ACK;
								link_nxt.ack_next = i2crb_pkg::ST_RDATA;
							end
						end
					end
					default: begin
						link_nxt.sda_oe = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_link_clk or posedge i_rst) begin
		if (i_rst) begin
			link_r <= '0;
		end else begin
			link_r <= link_nxt;
		end
	end

	// system domain: register bank behind a toggle handshake
	always_comb begin
		sys_nxt = sys_r;
		sys_nxt.req_m = link_r.req_tgl;
		sys_nxt.req_s = sys_r.req_m;
		if (i_ce) begin
			sys_nxt.req_q = sys_r.req_s;
			sys_nxt.cfg_wr = 1'b0;
			// payload was set with the toggle and has long settled by now
			if (sys_r.req_s != sys_r.req_q) begin
				sys_nxt.ack_tgl = ~sys_r.ack_tgl;
				if (link_r.req.wr) begin
					if (bank_is_rw(link_r.req.addr)) begin
						sys_nxt.bank[link_r.req.addr] = link_r.req.data;
						sys_nxt.cfg_wr = 1'b1;
						sys_nxt.cfg_addr = link_r.req.addr;
						sys_nxt.cfg_data = link_r.req.data;
					end
					// other locations: byte was acknowledged, nothing stored
				end else begin
					sys_nxt.rd_data = bank_read(link_r.req.addr, sys_r.bank, i_ro_bank);
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			sys_r <= '0;
		end else begin
			sys_r <= sys_nxt;
		end
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe = link_r.sda_oe;
	assign o_cfg_wr = sys_r.cfg_wr;
	assign o_cfg_addr = sys_r.cfg_addr;
	assign o_cfg_data = sys_r.cfg_data;
	assign o_cfg_bank = sys_r.bank;

endmodule
`default_nettype wire

// [shared/i2crb_pkg.sv]
`default_nettype none
package i2crb_pkg;

	// register bank geometry
	localparam int BANK_DEPTH = 128;
	localparam int RO_DEPTH = 32;
	localparam logic [6:0] RW_LAST = 7'h50;
	localparam logic [6:0] RO_FIRST = 7'h60;
	localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
	localparam logic [7:0] BANK_RESET = 8'h00;

	// fixed upper part of the 7-bit device address
	localparam logic [4:0] DEV_ADDR_BASE = 5'h08;

	// serial framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] BIT_ONE = 4'h1;
	localparam logic [6:0] PTR_STEP = 7'h01;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK = 3'b010,
		ST_REG = 3'b011,
		ST_WDATA = 3'b100,
		ST_RDATA = 3'b101,
		ST_RACK = 3'b110
	} i2crb_state_t;

	// access passed from the link domain to the system domain
	typedef struct packed {
		logic wr;
		logic [6:0] addr;
		logic [7:0] data;
	} i2crb_req_t;

	// pointer wraps from the top of the bank back to zero
	function automatic logic [6:0] i2crb_ptr_inc(input logic [6:0] ptr);
		i2crb_ptr_inc = ptr + PTR_STEP;
	endfunction

endpackage
`default_nettype wire

// [tb/i2crb_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module i2crb_assertions (
	// clocks and reset
	input wire logic i_sys_clk,
	input wire logic i_link_clk,
	input wire logic i_rst,
	// bus pins
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda_out,
	input wire logic o_sda_oe,
	// user side
	input wire logic o_cfg_wr,
	input wire logic [6:0] o_cfg_addr,
	input wire logic [7:0] o_cfg_data,
	input wire logic [80:0][7:0] o_cfg_bank
);
	a_sda_open_drain: assert property (@(posedge i_link_clk) disable iff (i_rst)
		o_sda_out == 1'h0) else $error("data pin driven high");
	a_ack_on_low: assert property (@(posedge i_link_clk) disable iff (i_rst)
		$rose(o_sda_oe) |-> !i_scl) else $error("data pulled while clock high");
	a_ack_holds_high: assert property (@(posedge i_link_clk) disable iff (i_rst)
		o_sda_oe && i_scl ##1 i_scl |-> o_sda_oe) else $error("data let go while clock high");
	a_stop_releases: assert property (@(posedge i_link_clk) disable iff (i_rst)
		i_scl && $rose(i_sda) |=> !o_sda_oe [*8]) else $error("data pulled after stop");
	a_wr_single: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_cfg_wr |=> !o_cfg_wr) else $error("write pulse too long");
	a_ro_unstored: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_cfg_wr |-> o_cfg_addr <= i2crb_pkg::RW_LAST) else $error("store outside rw area");
	a_bank_follows: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_cfg_wr |-> o_cfg_bank[o_cfg_addr] == o_cfg_data) else $error("bank misses write");
	a_bank_holds: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!o_cfg_wr |-> $stable(o_cfg_bank) && $stable(o_cfg_addr)) else $error("bank moved");
endmodule
bind i2crb_slave i2crb_assertions u_chk (.i_sys_clk(i_sys_clk), .i_link_clk(i_link_clk),
	.i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
	.o_cfg_wr(o_cfg_wr), .o_cfg_addr(o_cfg_addr), .o_cfg_data(o_cfg_data),
	.o_cfg_bank(o_cfg_bank));
`default_nettype wire

// [tb/i2crb_master.sv]
`timescale 1ns/10ps
`default_nettype none
module i2crb_master (
	// pacing and resolved data line
	input wire logic i_sys_clk,
	input wire logic i_sda,
	// bus drive, data only ever pulled low
	output logic o_scl,
	output logic o_sda_low
);
	initial begin
		o_scl = 1'h1;
		o_sda_low = 1'h0;
	end
	// three steps of 84 cycles a bit keep the rate just under 100 kHz
	task automatic step(input logic c, input logic l);
		o_scl = c;
		o_sda_low = l;
		repeat (84) @(negedge i_sys_clk);
	endtask
	// start (also repeated) or stop: data is set up with the clock low, then flips while the clock is high
	task automatic cond(input logic a);
		step(1'h0, o_sda_low);
		step(1'h0, a);
		step(1'h1, a);
		step(1'h1, !a);
	endtask
	// msb first, zero pulls low, one releases; sampled with the clock high
	task automatic xfer(input logic [8:0] w, output logic [8:0] v);
		for (int k = 8; k >= 0; k--) begin
			step(1'h0, o_sda_low);
			step(1'h0, !w[k]);
			step(1'h1, !w[k]);
			v[k] = i_sda;
		end
	endtask
endmodule
`default_nettype wire

// [tb/test_i2c_slave_register_bank.sv]
`timescale 1ns/10ps
`default_nettype none
module test_i2c_slave_register_bank;
	localparam logic [7:0] DW = {i2crb_pkg::DEV_ADDR_BASE, 2'h3, 1'h0};
	logic i_sys_clk, i_link_clk, i_rst, scl, low, stl, sth, oe, wr, sda, ce;
	logic [31:0][7:0] ro;
	logic [6:0] ca;
	logic [7:0] cd;
	logic [80:0][7:0] bank;
	// strap pair, pointer, data
	logic [17:0] rows [4] = '{18'h000A5, 18'h1015A, 18'h2023C, 18'h303C3};
	int n_fail = 0;
	int check_count = 0;
	assign sda = !(low || oe);
	i2crb_slave dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(ce), .i_link_clk(i_link_clk),
		.i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(oe), .i_addr_strap_low(stl),
		.i_addr_strap_high(sth), .i_ro_bank(ro), .o_cfg_wr(wr), .o_cfg_addr(ca),
		.o_cfg_data(cd), .o_cfg_bank(bank));
	i2crb_master m (.i_sys_clk(i_sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(low));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tx(input logic [7:0] d, input logic [7:0] ak);
		logic [8:0] v;
		m.xfer({d, 1'h1}, v);
		check({7'h00, v[0]}, ak);
	endtask
	task automatic rx(input logic n, input logic [7:0] e);
		logic [8:0] v;
		m.xfer({8'hFF, n}, v);
		check(v[8:1], e);
	endtask
	task automatic summarize;
		if (n_fail == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		i_sys_clk = 1'h0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end
	// phase offset keeps the two clocks unrelated
	initial begin
		i_link_clk = 1'h0;
		#7;
		forever #16 i_link_clk = ~i_link_clk;
	end
	initial begin
		repeat (100000) @(posedge i_sys_clk);
		n_fail++;
		summarize;
	end
	initial begin
		i_rst = 1'h1;
		ce = 1'h1;
		{sth, stl} = 2'h0;
		for (int k = 0; k < 32; k++) begin
			ro[k] = 8'h80 + 8'(k);
		end
		repeat (5) @(negedge i_sys_clk);
		i_rst = 1'h0;
		for (int k = 0; k < 4; k++) begin
			{sth, stl} = rows[k][17:16];
			m.step(1'h1, 1'h0);
			m.cond(1'h0);
			tx({i2crb_pkg::DEV_ADDR_BASE, rows[k][17:16], 1'h0}, 8'h00);
			tx(rows[k][15:8], 8'h00);
			tx(rows[k][7:0], 8'h00);
			m.cond(1'h1);
			check(bank[rows[k][14:8]], rows[k][7:0]);
		end
		m.cond(1'h0);
		tx({i2crb_pkg::DEV_ADDR_BASE, 2'h0, 1'h0}, 8'h01);
		tx(8'h00, 8'h01);
		m.cond(1'h1);
		m.cond(1'h0);
		tx(DW, 8'h00);
		tx(8'h4F, 8'h00);
		tx(8'hA1, 8'h00);
		tx(8'hB2, 8'h00);
		tx(8'hC3, 8'h00);
		m.cond(1'h1);
		check(bank[79], 8'hA1);
		check(bank[80], 8'hB2);
		check({1'h0, ca}, 8'h50);
		check(cd, 8'hB2);
		m.cond(1'h0);
		tx(DW, 8'h00);
		tx(8'h7F, 8'h00);
		m.cond(1'h0);
		tx(DW | 8'h01, 8'h00);
		rx(1'h0, 8'h9F);
		rx(1'h0, rows[0][7:0]);
		rx(1'h1, rows[1][7:0]);
		m.cond(1'h1);
		check({7'h00, sda}, 8'h01);
		// frozen block must not answer even its own address
		ce = 1'h0;
		m.step(1'h1, 1'h0);
		m.cond(1'h0);
		tx(DW, 8'h01);
		m.cond(1'h1);
		ce = 1'h1;
		m.step(1'h1, 1'h0);
		check({7'h00, sda}, 8'h01);
		i_rst = 1'h1;
		repeat (5) @(negedge i_sys_clk);
		check(bank[80], 8'h00);
		check({7'h00, wr}, 8'h00);
		i_rst = 1'h0;
		summarize;
	end
endmodule
`default_nettype wire
